/* File: design/hpcc_cfg.svh */
`ifndef HPCC_CFG_SVH
`define HPCC_CFG_SVH
// Contract
// - Four-bit in-use mask, bit n is port n+1
// - Mask writable only when removable override set
// - Legacy-speed-only port forced used and enabled (code forces port_enabled only; used mask keeps its value)
// - Reserved bits read only, read zero
// - Config bits 3:2 plain read-write storage
// - Divider select follows default unless override set
// - Override and divider select written together
// - Polarity loaded from strap at reset release
// - Enable outputs low-active or high-active by polarity
// - I2C mode loads polarity from EEPROM
// - SMBus host may overwrite polarity
// - Divider select picks profile two or three
// - Auto disable zero enables automatic mode
// - Upstream connected gives CDP on charging ports
// - Per-port charge enable gates automatic and CDP
// - Mask from defaults unless override, else loadable
`define HPCC_OFS_USED 8'h08
`define HPCC_OFS_CFG2 8'h0A
`define HPCC_CFG2_OVR 6
`define HPCC_CFG2_POL 5
`define HPCC_CFG2_DIV 4
`define HPCC_CFG2_SPH 3
`define HPCC_CFG2_SPL 2
`define HPCC_CFG2_AUTO 1
`define HPCC_USED_OVR 7
`define HPCC_USED_RST 4'hF
`endif

/* File: design/hpcc_pkg.sv */
package hpcc_pkg;
  typedef enum logic [1:0] {
    HPCC_CHG_OFF = 2'b00,
    HPCC_CHG_AUTO = 2'b01,
    HPCC_CHG_DCP_CDP = 2'b10,
    HPCC_CHG_CDP = 2'b11
  } hpcc_chg_mode_t;
  typedef enum logic [0:0] {
    HPCC_DIV_TWO = 1'b0,
    HPCC_DIV_THREE = 1'b1
  } hpcc_div_t;
endpackage : hpcc_pkg

/* File: design/hpcc_port_ctl.sv */
`timescale 1ns/10ps
// One downstream port's charge mode and switch drive
module hpcc_port_ctl (
  // Port settings
  input wire logic charge_en,
  input wire logic upstream_connected,
  input wire logic auto_disable,
  input wire logic polarity,
  input wire logic power_on,
  // Results
  output hpcc_pkg::hpcc_chg_mode_t mode,
  output logic switch_level
);
  always_comb begin
    if (!charge_en) begin
      mode = hpcc_pkg::HPCC_CHG_OFF;
    end else if (upstream_connected) begin
      mode = hpcc_pkg::HPCC_CHG_CDP;
    end else if (!auto_disable) begin
      mode = hpcc_pkg::HPCC_CHG_AUTO;
    end else begin
      mode = hpcc_pkg::HPCC_CHG_DCP_CDP;
    end
  end
  // Polarity 1 means active high
  assign switch_level = polarity ? power_on : ~power_on;
endmodule : hpcc_port_ctl

/* File: design/hpcc_regs.sv */
`timescale 1ns/10ps
`include "hpcc_cfg.svh"
module hpcc_regs #(
  parameter int PORTS = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register access
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] used_rdata,
  output logic [7:0] cfg2_rdata,
  // EEPROM load source and mode
  input wire logic i2c_mode,
  input wire logic smbus_mode,
  input wire logic eeprom_wr,
  // Defaults and strap
  input wire logic [PORTS-1:0] otp_used,
  input wire logic otp_div_sel,
  input wire logic power_switch_polarity_strap,
  // Controls from other registers
  input wire logic custom_removable_override,
  input wire logic [PORTS-1:0] legacy_speed_only_select,
  input wire logic [PORTS-1:0] charge_port_enable,
  input wire logic upstream_connected,
  input wire logic [PORTS-1:0] power_on,
  // Results
  output logic [PORTS-1:0] port_enabled,
  output logic [PORTS-1:0] power_switch_enable_out,
  output hpcc_pkg::hpcc_chg_mode_t [PORTS-1:0] charge_mode,
  output hpcc_pkg::hpcc_div_t divider_profile
);
  typedef struct packed {
    logic [PORTS-1:0] used;
    logic charge_feature_override;
    logic power_switch_polarity;
    logic high_current_divider_select;
    logic [1:0] spare;
    logic automatic_charge_disable;
    logic strap_pending;
  } hpcc_state_t;

  hpcc_state_t st_reg;
  hpcc_state_t st_next;
  logic wr_any;
  logic wr_used;
  logic wr_cfg2;
  logic pol_wr_ok;

  // Host writes in SMBus mode, loader writes in I2C mode
  assign wr_any = (reg_wr & smbus_mode) | (eeprom_wr & i2c_mode);
  assign wr_used = wr_any && reg_addr == `HPCC_OFS_USED;
  assign wr_cfg2 = wr_any && reg_addr == `HPCC_OFS_CFG2;
  assign pol_wr_ok = (eeprom_wr & i2c_mode) | (reg_wr & smbus_mode);

  always_comb begin
    st_next = st_reg;
    st_next.strap_pending = 1'b0;
    // Strap caught on first clock after release, never under reset
    if (st_reg.strap_pending) begin
      st_next.power_switch_polarity = power_switch_polarity_strap;
    end
    if (!custom_removable_override) begin
      st_next.used = otp_used;
    end else if (wr_used) begin
      st_next.used = reg_wdata[PORTS-1:0];
    end
    if (wr_cfg2) begin
      st_next.charge_feature_override = reg_wdata[`HPCC_CFG2_OVR];
      st_next.spare = reg_wdata[`HPCC_CFG2_SPH:`HPCC_CFG2_SPL];
      st_next.automatic_charge_disable = reg_wdata[`HPCC_CFG2_AUTO];
      if (pol_wr_ok && !st_reg.strap_pending) begin
        st_next.power_switch_polarity = reg_wdata[`HPCC_CFG2_POL];
      end
    end
    // New override value counts in the same write
    if (!st_next.charge_feature_override) begin
      st_next.high_current_divider_select = otp_div_sel;
    end else if (wr_cfg2) begin
      st_next.high_current_divider_select = reg_wdata[`HPCC_CFG2_DIV];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '{used: `HPCC_USED_RST, charge_feature_override: 1'b0, power_switch_polarity: 1'b0,
                  high_current_divider_select: 1'b0, spare: 2'b00, automatic_charge_disable: 1'b0,
                  strap_pending: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign used_rdata = {4'h0, st_reg.used};
  assign cfg2_rdata = {1'b0, st_reg.charge_feature_override, st_reg.power_switch_polarity,
                       st_reg.high_current_divider_select, st_reg.spare, st_reg.automatic_charge_disable,
                       1'b0};
  assign port_enabled = st_reg.used | legacy_speed_only_select;
  assign divider_profile = hpcc_pkg::hpcc_div_t'(st_reg.high_current_divider_select);

  for (genvar i = 0; i < PORTS; i++) begin : g_port
    hpcc_port_ctl u_port (
      .charge_en(charge_port_enable[i]),
      .upstream_connected(upstream_connected),
      .auto_disable(st_reg.automatic_charge_disable),
      .polarity(st_reg.power_switch_polarity),
      .power_on(power_on[i]),
      .mode(charge_mode[i]),
      .switch_level(power_switch_enable_out[i])
    );
  end

  // Strap lands at the first edge after release, seen one edge later
  chk_strap_load: assert property (@(posedge clk) disable iff (srst)
    $past(srst, 2) && !$past(srst) |-> st_reg.power_switch_polarity == $past(power_switch_polarity_strap))
    else $error("polarity not taken from strap");
  chk_used_locked: assert property (@(posedge clk) disable iff (srst)
    !$past(custom_removable_override) && !$past(srst) |-> st_reg.used == $past(otp_used))
    else $error("mask changed while locked");
  chk_used_write: assert property (@(posedge clk) disable iff (srst)
    $past(custom_removable_override) && $past(wr_used) |-> st_reg.used == $past(reg_wdata[3:0]))
    else $error("mask write lost");
  chk_legacy_force: assert property (@(posedge clk) disable iff (srst)
    (legacy_speed_only_select & ~port_enabled) == 4'h0)
    else $error("legacy port not enabled");
  chk_rsvd_zero: assert property (@(posedge clk) disable iff (srst)
    cfg2_rdata[7] == 1'b0 && cfg2_rdata[0] == 1'b0 && used_rdata[7:4] == 4'h0)
    else $error("reserved bit nonzero");
  chk_div_locked: assert property (@(posedge clk) disable iff (srst)
    !st_reg.charge_feature_override && !$past(srst) |-> st_reg.high_current_divider_select == $past(otp_div_sel))
    else $error("divider select not default");
  chk_div_same: assert property (@(posedge clk) disable iff (srst)
    $past(wr_cfg2) && $past(reg_wdata[6]) |-> st_reg.high_current_divider_select == $past(reg_wdata[4]))
    else $error("divider write dropped");
  chk_spare_keep: assert property (@(posedge clk) disable iff (srst)
    $past(wr_cfg2) |-> cfg2_rdata[3:2] == $past(reg_wdata[3:2]))
    else $error("spare bits lost");
  chk_switch_pol: assert property (@(posedge clk) disable iff (srst)
    power_switch_enable_out == (st_reg.power_switch_polarity ? power_on : ~power_on))
    else $error("switch polarity wrong");
  chk_cdp_conn: assert property (@(posedge clk) disable iff (srst)
    upstream_connected && charge_port_enable[0] |-> charge_mode[0] == hpcc_pkg::HPCC_CHG_CDP)
    else $error("no CDP when connected");
  chk_reset_values: assert property (@(posedge clk) disable iff (srst)
    $past(srst)
    |-> used_rdata == {4'h0, `HPCC_USED_RST} && cfg2_rdata == 8'h00)
    else $error("register not at reset value");
  chk_pending_once: assert property (@(posedge clk) disable iff (srst)
    !$past(srst)
    |-> !st_reg.strap_pending)
    else $error("strap load repeated");
  chk_ovr_write: assert property (@(posedge clk) disable iff (srst)
    $past(wr_cfg2)
    |-> cfg2_rdata[6] == $past(reg_wdata[6]))
    else $error("override write lost");
  chk_auto_write: assert property (@(posedge clk) disable iff (srst)
    $past(wr_cfg2)
    |-> cfg2_rdata[1] == $past(reg_wdata[1]))
    else $error("auto disable write lost");
  chk_pol_write: assert property (@(posedge clk) disable iff (srst)
    $past(wr_cfg2) && !$past(st_reg.strap_pending)
    |-> cfg2_rdata[5] == $past(reg_wdata[5]))
    else $error("polarity write lost");
  chk_cfg2_hold: assert property (@(posedge clk) disable iff (srst)
    !$past(wr_cfg2) && !$past(srst)
    |-> $stable(cfg2_rdata[6]) && $stable(cfg2_rdata[3:1]))
    else $error("config bits changed without write");
  chk_pol_hold: assert property (@(posedge clk) disable iff (srst)
    !$past(wr_cfg2) && !$past(st_reg.strap_pending) && !$past(srst)
    |-> $stable(cfg2_rdata[5]))
    else $error("polarity changed without write");
  chk_smbus_gate: assert property (@(posedge clk) disable iff (srst)
    $past(reg_wr) && !$past(smbus_mode) && !$past(eeprom_wr && i2c_mode) && !$past(st_reg.strap_pending) && !$past(srst)
    |-> $stable(cfg2_rdata[6:5]) && $stable(cfg2_rdata[3:1]))
    else $error("host write taken outside SMBus mode");
  chk_eep_gate: assert property (@(posedge clk) disable iff (srst)
    $past(eeprom_wr) && !$past(i2c_mode) && !$past(reg_wr && smbus_mode) && !$past(st_reg.strap_pending) && !$past(srst)
    |-> $stable(cfg2_rdata[6:5]) && $stable(cfg2_rdata[3:1]))
    else $error("loader write taken outside I2C mode");
  chk_addr_gate: assert property (@(posedge clk) disable iff (srst)
    $past(wr_any) && $past(reg_addr) != `HPCC_OFS_USED && $past(reg_addr) != `HPCC_OFS_CFG2 && !$past(srst)
    |-> $stable(cfg2_rdata[6:5]) && $stable(cfg2_rdata[3:1]))
    else $error("write to other offset changed config");
  chk_div_hold: assert property (@(posedge clk) disable iff (srst)
    st_reg.charge_feature_override && $past(st_reg.charge_feature_override) && !$past(wr_cfg2) && !$past(srst)
    |-> $stable(st_reg.high_current_divider_select))
    else $error("divider select changed without write");
  chk_div_unlock: assert property (@(posedge clk) disable iff (srst)
    $past(wr_cfg2) && !$past(reg_wdata[6])
    |-> st_reg.high_current_divider_select == $past(otp_div_sel))
    else $error("divider written while locked");
  chk_used_hold: assert property (@(posedge clk) disable iff (srst)
    $past(custom_removable_override) && !$past(wr_used) && !$past(srst)
    |-> $stable(used_rdata))
    else $error("mask changed without write");
  // Per-port checks spelled out so a single stuck port is named
  chk_legacy_port0: assert property (@(posedge clk) disable iff (srst)
    legacy_speed_only_select[0]
    |-> port_enabled[0])
    else $error("port 1 legacy not enabled");
  chk_legacy_port1: assert property (@(posedge clk) disable iff (srst)
    legacy_speed_only_select[1]
    |-> port_enabled[1])
    else $error("port 2 legacy not enabled");
  chk_legacy_port2: assert property (@(posedge clk) disable iff (srst)
    legacy_speed_only_select[2]
    |-> port_enabled[2])
    else $error("port 3 legacy not enabled");
  chk_legacy_port3: assert property (@(posedge clk) disable iff (srst)
    legacy_speed_only_select[3]
    |-> port_enabled[3])
    else $error("port 4 legacy not enabled");
  chk_mask_port0: assert property (@(posedge clk) disable iff (srst)
    !legacy_speed_only_select[0]
    |-> port_enabled[0] == used_rdata[0])
    else $error("port 1 enable not from mask");
  chk_mask_port1: assert property (@(posedge clk) disable iff (srst)
    !legacy_speed_only_select[1]
    |-> port_enabled[1] == used_rdata[1])
    else $error("port 2 enable not from mask");
  chk_mask_port2: assert property (@(posedge clk) disable iff (srst)
    !legacy_speed_only_select[2]
    |-> port_enabled[2] == used_rdata[2])
    else $error("port 3 enable not from mask");
  chk_mask_port3: assert property (@(posedge clk) disable iff (srst)
    !legacy_speed_only_select[3]
    |-> port_enabled[3] == used_rdata[3])
    else $error("port 4 enable not from mask");
  chk_sw_high0: assert property (@(posedge clk) disable iff (srst)
    cfg2_rdata[5]
    |-> power_switch_enable_out[0] == power_on[0])
    else $error("port 1 switch not active high");
  chk_sw_high1: assert property (@(posedge clk) disable iff (srst)
    cfg2_rdata[5]
    |-> power_switch_enable_out[1] == power_on[1])
    else $error("port 2 switch not active high");
  chk_sw_high2: assert property (@(posedge clk) disable iff (srst)
    cfg2_rdata[5]
    |-> power_switch_enable_out[2] == power_on[2])
    else $error("port 3 switch not active high");
  chk_sw_high3: assert property (@(posedge clk) disable iff (srst)
    cfg2_rdata[5]
    |-> power_switch_enable_out[3] == power_on[3])
    else $error("port 4 switch not active high");
  chk_sw_low0: assert property (@(posedge clk) disable iff (srst)
    !cfg2_rdata[5]
    |-> power_switch_enable_out[0] == ~power_on[0])
    else $error("port 1 switch not active low");
  chk_sw_low1: assert property (@(posedge clk) disable iff (srst)
    !cfg2_rdata[5]
    |-> power_switch_enable_out[1] == ~power_on[1])
    else $error("port 2 switch not active low");
  chk_sw_low2: assert property (@(posedge clk) disable iff (srst)
    !cfg2_rdata[5]
    |-> power_switch_enable_out[2] == ~power_on[2])
    else $error("port 3 switch not active low");
  chk_sw_low3: assert property (@(posedge clk) disable iff (srst)
    !cfg2_rdata[5]
    |-> power_switch_enable_out[3] == ~power_on[3])
    else $error("port 4 switch not active low");
  chk_off_port0: assert property (@(posedge clk) disable iff (srst)
    !charge_port_enable[0]
    |-> charge_mode[0] == hpcc_pkg::HPCC_CHG_OFF)
    else $error("port 1 charging while disabled");
  chk_off_port1: assert property (@(posedge clk) disable iff (srst)
    !charge_port_enable[1]
    |-> charge_mode[1] == hpcc_pkg::HPCC_CHG_OFF)
    else $error("port 2 charging while disabled");
  chk_off_port2: assert property (@(posedge clk) disable iff (srst)
    !charge_port_enable[2]
    |-> charge_mode[2] == hpcc_pkg::HPCC_CHG_OFF)
    else $error("port 3 charging while disabled");
  chk_off_port3: assert property (@(posedge clk) disable iff (srst)
    !charge_port_enable[3]
    |-> charge_mode[3] == hpcc_pkg::HPCC_CHG_OFF)
    else $error("port 4 charging while disabled");
  chk_cdp_port1: assert property (@(posedge clk) disable iff (srst)
    upstream_connected && charge_port_enable[1]
    |-> charge_mode[1] == hpcc_pkg::HPCC_CHG_CDP)
    else $error("port 2 no CDP when connected");
  chk_cdp_port2: assert property (@(posedge clk) disable iff (srst)
    upstream_connected && charge_port_enable[2]
    |-> charge_mode[2] == hpcc_pkg::HPCC_CHG_CDP)
    else $error("port 3 no CDP when connected");
  chk_cdp_port3: assert property (@(posedge clk) disable iff (srst)
    upstream_connected && charge_port_enable[3]
    |-> charge_mode[3] == hpcc_pkg::HPCC_CHG_CDP)
    else $error("port 4 no CDP when connected");
  chk_auto_port0: assert property (@(posedge clk) disable iff (srst)
    !upstream_connected && charge_port_enable[0] && !cfg2_rdata[1]
    |-> charge_mode[0] == hpcc_pkg::HPCC_CHG_AUTO)
    else $error("port 1 not in automatic mode");
  chk_auto_port1: assert property (@(posedge clk) disable iff (srst)
    !upstream_connected && charge_port_enable[1] && !cfg2_rdata[1]
    |-> charge_mode[1] == hpcc_pkg::HPCC_CHG_AUTO)
    else $error("port 2 not in automatic mode");
  chk_auto_port2: assert property (@(posedge clk) disable iff (srst)
    !upstream_connected && charge_port_enable[2] && !cfg2_rdata[1]
    |-> charge_mode[2] == hpcc_pkg::HPCC_CHG_AUTO)
    else $error("port 3 not in automatic mode");
  chk_auto_port3: assert property (@(posedge clk) disable iff (srst)
    !upstream_connected && charge_port_enable[3] && !cfg2_rdata[1]
    |-> charge_mode[3] == hpcc_pkg::HPCC_CHG_AUTO)
    else $error("port 4 not in automatic mode");
  chk_dcp_port0: assert property (@(posedge clk) disable iff (srst)
    !upstream_connected && charge_port_enable[0] && cfg2_rdata[1]
    |-> charge_mode[0] == hpcc_pkg::HPCC_CHG_DCP_CDP)
    else $error("port 1 not restricted to DCP and CDP");
  chk_dcp_port1: assert property (@(posedge clk) disable iff (srst)
    !upstream_connected && charge_port_enable[1] && cfg2_rdata[1]
    |-> charge_mode[1] == hpcc_pkg::HPCC_CHG_DCP_CDP)
    else $error("port 2 not restricted to DCP and CDP");
  chk_dcp_port2: assert property (@(posedge clk) disable iff (srst)
    !upstream_connected && charge_port_enable[2] && cfg2_rdata[1]
    |-> charge_mode[2] == hpcc_pkg::HPCC_CHG_DCP_CDP)
    else $error("port 3 not restricted to DCP and CDP");
  chk_dcp_port3: assert property (@(posedge clk) disable iff (srst)
    !upstream_connected && charge_port_enable[3] && cfg2_rdata[1]
    |-> charge_mode[3] == hpcc_pkg::HPCC_CHG_DCP_CDP)
    else $error("port 4 not restricted to DCP and CDP");
endmodule : hpcc_regs

/* File: testbench/hpcc_host_model.sv */
`timescale 1ns/10ps
// Host or EEPROM loader writing single bytes
module hpcc_host_model (
  // Clock
  input wire logic clk,
  // Write side
  output logic reg_wr,
  output logic eeprom_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    eeprom_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // One strobe cycle; lines inverted after release so stale data never looks valid
  task automatic put(input logic eep, input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = !eep;
    eeprom_wr = eep;
    @(negedge clk);
    reg_wr = 1'b0;
    eeprom_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    @(negedge clk);
  endtask : put
endmodule : hpcc_host_model

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0, srst = 1'b1, i2c_mode = 1'b0, smbus_mode = 1'b1, otp_div_sel = 1'b0, strap = 1'b1;
  logic cro = 1'b0, upc = 1'b0, reg_wr, eeprom_wr;
  logic [7:0] reg_addr, reg_wdata, used_rdata, cfg2_rdata;
  logic [3:0] otp_used = 4'hA, lso = 4'h0, cpe = 4'hE, pwr = 4'h5, port_enabled, pse;
  hpcc_pkg::hpcc_chg_mode_t [3:0] charge_mode;
  hpcc_pkg::hpcc_div_t divider_profile;
  int n_errors = 0, checks = 0;
  initial forever #2.5 clk = ~clk;
  hpcc_host_model u_host (.clk(clk), .reg_wr(reg_wr), .eeprom_wr(eeprom_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));
  hpcc_regs DUT (.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .used_rdata(used_rdata), .cfg2_rdata(cfg2_rdata), .i2c_mode(i2c_mode), .smbus_mode(smbus_mode),
    .eeprom_wr(eeprom_wr), .otp_used(otp_used), .otp_div_sel(otp_div_sel),
    .power_switch_polarity_strap(strap), .custom_removable_override(cro), .legacy_speed_only_select(lso),
    .charge_port_enable(cpe), .upstream_connected(upc), .power_on(pwr), .port_enabled(port_enabled),
    .power_switch_enable_out(pse), .charge_mode(charge_mode), .divider_profile(divider_profile));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // Whole run is under a hundred cycles
  initial begin
    #5000;
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (5) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    check(used_rdata, 8'h0A);
    check(cfg2_rdata, 8'h20);
    check({4'h0, pse}, 8'h05);
    $display("test reset done");
    u_host.put(1'b0, 8'h0A, 8'hFF);
    check(cfg2_rdata, 8'h7E);
    check({7'h00, divider_profile}, 8'h01);
    u_host.put(1'b0, 8'h0A, 8'h40);
    check(cfg2_rdata, 8'h40);
    check({4'h0, pse}, 8'h0A);
    otp_div_sel = 1'b1;
    u_host.put(1'b0, 8'h0A, 8'h0C);
    check(cfg2_rdata, 8'h1C);
    u_host.put(1'b0, 8'h0B, 8'hFF);
    check(cfg2_rdata, 8'h1C);
    $display("test config done");
    u_host.put(1'b0, 8'h08, 8'h03);
    check(used_rdata, 8'h0A);
    cro = 1'b1;
    u_host.put(1'b0, 8'h08, 8'hF3);
    check(used_rdata, 8'h03);
    lso = 4'h4;
    @(negedge clk);
    check({4'h0, port_enabled}, 8'h07);
    lso = 4'hB;
    @(negedge clk);
    check({4'h0, port_enabled}, 8'h0B);
    $display("test mask done");
    smbus_mode = 1'b0;
    u_host.put(1'b0, 8'h0A, 8'h20);
    check(cfg2_rdata, 8'h1C);
    u_host.put(1'b1, 8'h0A, 8'h20);
    check(cfg2_rdata, 8'h1C);
    i2c_mode = 1'b1;
    u_host.put(1'b1, 8'h0A, 8'h20);
    check(cfg2_rdata, 8'h30);
    check(charge_mode, 8'h54);
    u_host.put(1'b1, 8'h0A, 8'h22);
    check(charge_mode, 8'hA8);
    upc = 1'b1;
    @(negedge clk);
    check(charge_mode, 8'hFC);
    cpe = 4'h1;
    @(negedge clk);
    check(charge_mode, 8'h03);
    upc = 1'b0;
    @(negedge clk);
    check(charge_mode, 8'h02);
    u_host.put(1'b1, 8'h0A, 8'h20);
    check(charge_mode, 8'h01);
    $display("test modes done");
    end_sim();
  end
endmodule : testbench
